// >>> acc_pkg.sv
// package for the analog comparator control block
package acc_pkg;
    // register word indices; the byte address is four times the index
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_WIN = 4'h1;
    localparam logic [3:0] IDX_MUX = 4'h2;
    localparam logic [3:0] IDX_REF = 4'h5;
    localparam logic [3:0] IDX_IRQ = 4'h6;
    localparam logic [3:0] IDX_STAT = 4'h7;
    localparam int ADDR_W = 6;
    // field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_PADOE = 6;
    localparam int CTRL_RUNSTBY = 7;
    localparam int MUX_INV = 7;
    localparam int MUX_INIT = 6;
    localparam int IRQ_EN = 0;
    localparam int STAT_FLAG = 0;
    localparam int STAT_STATE = 4;
    // writable bit masks and the reference code reset value
    localparam logic [7:0] CTRL_MASK = 8'hdf;
    localparam logic [7:0] WIN_MASK = 8'h03;
    localparam logic [7:0] MUX_MASK = 8'hff;
    localparam logic [7:0] IRQ_MASK = 8'h31;
    localparam logic [7:0] REF_RESET = 8'hff;
    // synchronizer stages to the readable state bit
    localparam int SYNC_STAGES = 3;
    // codes
    localparam logic [1:0] WPOS_ABOVE = 2'h0;
    localparam logic [1:0] WPOS_INSIDE = 2'h1;
    localparam logic [1:0] WPOS_BELOW = 2'h2;
    localparam logic [1:0] COND_ANY = 2'h0;
    localparam logic [1:0] COND_FALL = 2'h2;
    localparam logic [1:0] COND_RISE = 2'h3;
    localparam logic [1:0] COND_OUTSIDE = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {ST_OFF, ST_START, ST_RUN} acc_phase_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] win;
        logic [7:0] mux;
        logic [7:0] refCode;
        logic [7:0] irqCtl;
        logic flag;
    } acc_regs_t;

    typedef struct packed {
        logic padOut;
        logic padOe;
        logic resultOut;
        logic irq;
    } acc_outs_t;
endpackage : acc_pkg

// >>> acc_comparator_ctrl.sv
// digital control and status logic around one analog comparator
//
// Overview of operation
// - control bit 0 switches the comparator on; zero keeps it off
// - run-in-standby bit 7 keeps operation in standby; flags then frozen
// - result drives the pad only while pad output enable bit 6 is set
// - current profile field bits 4:3 picks profile 0..2; code 3 reserved
// - hysteresis field bits 2:1 picks none, small, medium, large
// - window partner: 0 off, 1 next instance, 2 two above, 3 reserved
// - polarity bit 7 of input select inverts the outputs and the non-window state bit, not irq conditions
// - before ready the output holds the startup level bit 6
// - positive select bits 5:3 route positive pins 0 to 3
// - negative select bits 2:0 route pins 0..2 or divider reference
// - 8-bit reference divider code resets to 0xff; level code/256
// - window irq condition: above, inside, below, outside
// - single irq condition: any crossing, fall at 2, rise at 3
// - interrupt request needs enable bit and compare flag both set
// - window position reads above 0, inside 1, below 2
// - compare state mirrors result, or window match in window use
// - compare state passes a three-stage synchronizer
// - compare flag set on condition; write one clears it
// - result high when positive exceeds negative; xor with polarity
// - interrupt request holds until the flag is cleared
// - power-down disables comparator and pad output
`timescale 1ns/10ps
`default_nettype none
module acc_comparator_ctrl
    import acc_pkg::*;
#(
    parameter int START_CYCLES = 16
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // power state
    input wire logic standby,
    input wire logic powerDown,
    // analog front end
    input wire logic rawCompare,
    input wire logic partnerCompare,
    output logic anaEnable,
    output logic [1:0] profileSel,
    output logic [1:0] hysteresisSel,
    output logic [2:0] positiveSel,
    output logic [2:0] negativeSel,
    output logic [7:0] refDividerCode,
    output logic [1:0] partnerSel,
    // results
    output logic padOut,
    output logic padOe,
    output logic resultOut,
    output logic irq
);
    typedef struct packed {
        acc_regs_t regs;
        acc_phase_t phase;
        logic [15:0] startCnt;
        logic [SYNC_STAGES-1:0] syncMain;
        logic [SYNC_STAGES-1:0] syncPart;
        logic prevHit;
        logic prevRes;
        logic wrPend;
        logic [3:0] wrIdx;
        logic [31:0] rdata;
        logic anaOn;
        acc_outs_t outs;
    } acc_state_t;

    acc_state_t s_q, s_d;

    function automatic logic [7:0] read_reg(input acc_state_t s,
                                            input logic [1:0] wpos,
                                            input logic cstate,
                                            input logic [3:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_CTRL: v = s.regs.ctrl;
            IDX_WIN: v = s.regs.win;
            IDX_MUX: v = s.regs.mux;
            IDX_REF: v = s.regs.refCode;
            IDX_IRQ: v = s.regs.irqCtl;
            IDX_STAT: v = {wpos, 1'b0, cstate, 3'h0, s.regs.flag};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    logic winOn, running, clkLive, resSync, partSync, upperHi, lowerHi;
    logic awake;
    logic [1:0] winPos;
    logic stateBit, hit, trig, rawOut;
    logic addrOk, wrHit;

    always_comb
    begin
        s_d = s_q;
        winOn = (s_q.regs.win[1:0] == 2'h1) || (s_q.regs.win[1:0] == 2'h2);
        // any sleep stops the block clock, so flags and edge history freeze;
        // run-in-standby keeps only the comparator and its pad path alive
        clkLive = !powerDown && !standby;
        awake = !powerDown &&
                (!standby || s_q.regs.ctrl[CTRL_RUNSTBY]);
        running = s_q.regs.ctrl[CTRL_EN] && awake;
        resSync = s_q.syncMain[SYNC_STAGES-1];
        partSync = s_q.syncPart[SYNC_STAGES-1];
        // this comparator sets the upper limit, the partner the lower
        upperHi = resSync;
        lowerHi = partSync;
        if (upperHi)
            winPos = WPOS_ABOVE;
        else if (lowerHi)
            winPos = WPOS_INSIDE;
        else
            winPos = WPOS_BELOW;
        if (winOn)
        begin
            if (s_q.regs.irqCtl[5:4] == COND_OUTSIDE)
                hit = winPos != WPOS_INSIDE;
            else
                hit = winPos == s_q.regs.irqCtl[5:4];
            stateBit = hit;
        end
        else
        begin
            hit = resSync;
            stateBit = resSync ^ s_q.regs.mux[MUX_INV];
        end
        trig = 1'b0;
        if (s_q.phase == ST_RUN)
        begin
            if (winOn)
                trig = hit && !s_q.prevHit;
            else
                case (s_q.regs.irqCtl[5:4])
                    COND_ANY: trig = resSync != s_q.prevRes;
                    COND_FALL: trig = !resSync && s_q.prevRes;
                    COND_RISE: trig = resSync && !s_q.prevRes;
                    default: trig = 1'b0;
                endcase
        end
        // the synchronizers track the comparator while it is awake; the
        // edge history waits for the block clock, so a crossing made in
        // standby is seen once on wake-up
        if (awake)
        begin
            s_d.syncMain = {s_q.syncMain[SYNC_STAGES-2:0], rawCompare};
            s_d.syncPart = {s_q.syncPart[SYNC_STAGES-2:0], partnerCompare};
        end
        if (clkLive)
        begin
            s_d.prevHit = hit;
            s_d.prevRes = resSync;
        end
        // start-up: output parked at startup level until ready
        case (s_q.phase)
            ST_OFF:
            begin
                s_d.startCnt = 16'h0000;
                if (running)
                    s_d.phase = ST_START;
            end
            ST_START:
            begin
                s_d.startCnt = s_q.startCnt + 16'h0001;
                if (!running)
                    s_d.phase = ST_OFF;
                else if (s_q.startCnt == 16'(START_CYCLES - 1))
                    s_d.phase = ST_RUN;
            end
            ST_RUN:
            begin
                if (!running)
                    s_d.phase = ST_OFF;
            end
            default: s_d.phase = ST_OFF;
        endcase
        // ahb-lite: address phase captured, write applied in data phase
        addrOk = hsel && hready && (htrans == HTRANS_NONSEQ);
        wrHit = addrOk && hwrite;
        s_d.wrPend = wrHit;
        if (wrHit)
            s_d.wrIdx = haddr[ADDR_W-1:2];
        if (addrOk && !hwrite)
            // window position reads zero while the window is off, as at reset
            s_d.rdata = {24'h0, read_reg(s_q, winOn ? winPos : WPOS_ABOVE,
                                         stateBit, haddr[ADDR_W-1:2])};
        if (s_q.wrPend)
        begin
            case (s_q.wrIdx)
                IDX_CTRL: s_d.regs.ctrl = hwdata[7:0] & CTRL_MASK;
                IDX_WIN: s_d.regs.win = hwdata[7:0] & WIN_MASK;
                IDX_MUX: s_d.regs.mux = hwdata[7:0] & MUX_MASK;
                IDX_REF: s_d.regs.refCode = hwdata[7:0];
                IDX_IRQ: s_d.regs.irqCtl = hwdata[7:0] & IRQ_MASK;
                default: s_d.regs = s_q.regs;
            endcase
            if (s_q.wrIdx == IDX_STAT && hwdata[STAT_FLAG])
                s_d.regs.flag = 1'b0;
        end
        if (trig && clkLive)
            s_d.regs.flag = 1'b1;
        // outputs
        if (s_q.phase == ST_RUN)
            rawOut = resSync ^ s_q.regs.mux[MUX_INV];
        else
            rawOut = s_q.regs.mux[MUX_INIT];
        s_d.outs.resultOut = rawOut;
        s_d.outs.padOut = rawOut;
        s_d.outs.padOe = s_q.regs.ctrl[CTRL_PADOE] && running;
        s_d.anaOn = running;
        s_d.outs.irq = s_d.regs.irqCtl[IRQ_EN] && s_d.regs.flag;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.regs.refCode <= REF_RESET;
            s_q.phase <= ST_OFF;
        end
        else
            s_q <= s_d;
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign anaEnable = s_q.anaOn;
    assign profileSel = s_q.regs.ctrl[4:3];
    assign hysteresisSel = s_q.regs.ctrl[2:1];
    assign positiveSel = s_q.regs.mux[5:3];
    assign negativeSel = s_q.regs.mux[2:0];
    assign refDividerCode = s_q.regs.refCode;
    assign partnerSel = s_q.regs.win[1:0];
    assign padOut = s_q.outs.padOut;
    assign padOe = s_q.outs.padOe;
    assign resultOut = s_q.outs.resultOut;
    assign irq = s_q.outs.irq;

    // irq is registered from the next-state flag, so it never lags it
    property p_irq_follows;
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |-> irq == (s_q.regs.flag && s_q.regs.irqCtl[IRQ_EN]);
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("irq does not follow flag and enable");

    property p_irq_holds;
        @(posedge sys_clk) disable iff (!rst_n)
        (irq && s_q.regs.flag && s_q.regs.irqCtl[IRQ_EN] && !s_q.wrPend)
        |=> irq;
    endproperty
    a_irq_holds: assert property (p_irq_holds)
        else $error("irq dropped while flag set");

    property p_pad_oe;
        @(posedge sys_clk) disable iff (!rst_n)
        !s_q.regs.ctrl[CTRL_PADOE] |=> !padOe;
    endproperty
    a_pad_oe: assert property (p_pad_oe)
        else $error("pad driven without output enable");

    property p_powerdown;
        @(posedge sys_clk) disable iff (!rst_n)
        powerDown |=> !anaEnable && !padOe;
    endproperty
    a_powerdown: assert property (p_powerdown)
        else $error("comparator active in power-down");

    property p_enable;
        @(posedge sys_clk) disable iff (!rst_n)
        (!s_q.regs.ctrl[CTRL_EN]) |=> !anaEnable;
    endproperty
    a_enable: assert property (p_enable)
        else $error("comparator on while enable is zero");

    property p_init_level;
        @(posedge sys_clk) disable iff (!rst_n)
        (s_q.phase != ST_RUN) |=> resultOut == $past(s_q.regs.mux[MUX_INIT]);
    endproperty
    a_init_level: assert property (p_init_level)
        else $error("output not at startup level");

    property p_sync_lat;
        @(posedge sys_clk) disable iff (!rst_n)
        (awake && rawCompare) ##1 awake ##1 awake
        |=> s_q.syncMain[SYNC_STAGES-1];
    endproperty
    a_sync_lat: assert property (p_sync_lat)
        else $error("state bit latency not three cycles");

    property p_flag_set;
        @(posedge sys_clk) disable iff (!rst_n)
        (trig && clkLive) |=> s_q.regs.flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("compare flag not set on condition");

    property p_standby_freeze;
        @(posedge sys_clk) disable iff (!rst_n)
        (!clkLive && !s_q.wrPend) |=> s_q.regs.flag == $past(s_q.regs.flag);
    endproperty
    a_standby_freeze: assert property (p_standby_freeze)
        else $error("flag changed while clock held");

    property p_flag_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        (s_q.wrPend && s_q.wrIdx == IDX_STAT && hwdata[STAT_FLAG] &&
         !(trig && clkLive)) |=> !s_q.regs.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("compare flag not cleared by writing one");

    property p_irq_off;
        @(posedge sys_clk) disable iff (!rst_n)
        (!s_q.regs.flag && !(trig && clkLive)) |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq raised without compare flag");

    property p_standby_run;
        @(posedge sys_clk) disable iff (!rst_n)
        (standby && !powerDown && s_q.regs.ctrl[CTRL_RUNSTBY] &&
         s_q.regs.ctrl[CTRL_EN]) |=> anaEnable;
    endproperty
    a_standby_run: assert property (p_standby_run)
        else $error("comparator stopped in standby with run enabled");

    property p_standby_halt;
        @(posedge sys_clk) disable iff (!rst_n)
        (standby && !s_q.regs.ctrl[CTRL_RUNSTBY]) |=> !anaEnable;
    endproperty
    a_standby_halt: assert property (p_standby_halt)
        else $error("comparator running in standby without run enabled");

    property p_sync_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !awake |=> $stable(s_q.syncMain);
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("synchronizer moved while halted");

    property p_pad_level;
        @(posedge sys_clk) disable iff (!rst_n)
        (s_q.phase == ST_RUN) |=>
        padOut == $past(s_q.syncMain[SYNC_STAGES-1] ^ s_q.regs.mux[MUX_INV]);
    endproperty
    a_pad_level: assert property (p_pad_level)
        else $error("pad level does not follow the synchronized result");

    property p_rise_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        (s_q.phase == ST_RUN && clkLive && $past(clkLive) && !winOn &&
         s_q.regs.irqCtl[5:4] == COND_RISE &&
         $rose(s_q.syncMain[SYNC_STAGES-1])) |=> s_q.regs.flag;
    endproperty
    a_rise_flag: assert property (p_rise_flag)
        else $error("rising crossing did not set the compare flag");

    property p_reserved_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (addrOk && !hwrite && (haddr[ADDR_W-1:2] == 4'h3 ||
         haddr[ADDR_W-1:2] == 4'h4)) |=> hrdata == 32'h0;
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("reserved offset read back nonzero");
endmodule : acc_comparator_ctrl
`default_nettype wire

// >>> acc_analog_model.sv
// behavioural model of the analog pins and the comparator pair
`timescale 1ns/10ps
`default_nettype none
module acc_analog_model
    import acc_pkg::*;
(
    // pin levels on a 0..255 scale
    input wire logic [31:0] posPins,
    input wire logic [23:0] negPins,
    input wire logic [7:0] lowerLimit,
    // selections from the block
    input wire logic anaEnable,
    input wire logic [2:0] positiveSel,
    input wire logic [2:0] negativeSel,
    input wire logic [7:0] refDividerCode,
    // decisions
    output logic rawCompare,
    output logic partnerCompare
);
    logic [7:0] posLvl;
    logic [7:0] negLvl;
    always_comb
    begin
        // reserved selections connect nothing: low on plus, high on minus
        if (positiveSel > 3'h3)
            posLvl = 8'h00;
        else
            posLvl = posPins[positiveSel[1:0]*8 +: 8];
        if (negativeSel == 3'h3)
            negLvl = refDividerCode;
        else if (negativeSel > 3'h3)
            negLvl = 8'hff;
        else
            negLvl = negPins[negativeSel[1:0]*8 +: 8];
        // a switched-off comparator makes no decision
        rawCompare = anaEnable && (posLvl > negLvl);
        partnerCompare = anaEnable && (posLvl > lowerLimit);
    end
endmodule : acc_analog_model
`default_nettype wire

// >>> tb_top.sv
// self-checking testbench for the comparator control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import acc_pkg::*;
    logic sysClk = 1'b0;
    logic rstN = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, standby = 1'b0, powerDown = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, posPins = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [23:0] negPins = 24'h000080;
    logic [7:0] lowerLimit = 8'h40;
    logic [31:0] hrdata;
    logic hready, hresp, rawCompare, partnerCompare, anaEnable;
    logic padOut, padOe, resultOut, irq;
    logic [1:0] profileSel, hysteresisSel, partnerSel;
    logic [2:0] positiveSel, negativeSel;
    logic [7:0] refDividerCode, rd;
    int failCount = 0, numChecks = 0, cycles = 0;

    always #2 sysClk = ~sysClk;

    acc_comparator_ctrl #(.START_CYCLES(8)) acc_comparator_ctrl_i (
        .sys_clk(sysClk), .rst_n(rstN), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .standby(standby), .powerDown(powerDown),
        .rawCompare(rawCompare), .partnerCompare(partnerCompare),
        .anaEnable(anaEnable), .profileSel(profileSel),
        .hysteresisSel(hysteresisSel), .positiveSel(positiveSel),
        .negativeSel(negativeSel), .refDividerCode(refDividerCode),
        .partnerSel(partnerSel), .padOut(padOut), .padOe(padOe),
        .resultOut(resultOut), .irq(irq));

    acc_analog_model acc_analog_model_i (
        .posPins(posPins), .negPins(negPins), .lowerLimit(lowerLimit),
        .anaEnable(anaEnable), .positiveSel(positiveSel),
        .negativeSel(negativeSel), .refDividerCode(refDividerCode),
        .rawCompare(rawCompare), .partnerCompare(partnerCompare));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge sysClk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failCount++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge sysClk);
    endtask : idle

    // one single-word transfer; read data is taken at the data-phase edge
    task automatic bus(input logic wr, input logic [3:0] idx,
        input logic [7:0] wd);
        @(posedge sysClk);
        hsel <= 1'b1;
        haddr <= {26'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge sysClk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge sysClk); while (hready !== 1'b1);
        rd = hrdata[7:0];
    endtask : bus

    task automatic pin(input logic [7:0] v);
        @(posedge sysClk);
        posPins[7:0] <= v;
        idle(8);
    endtask : pin

    task automatic t_reset();
        logic [7:0] exp [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'hff, 8'h0,
            8'h0};
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, 4'(i), 8'h0);
            check(rd, exp[i]);
        end
        check(refDividerCode, 8'hff);
        check(hresp, 8'h0);
    endtask : t_reset

    task automatic t_fields();
        logic [3:0] idx [5] = '{IDX_CTRL, IDX_WIN, IDX_MUX, IDX_IRQ, 4'h3};
        logic [7:0] msk [5] = '{CTRL_MASK, WIN_MASK, MUX_MASK, IRQ_MASK, 0};
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, idx[i], 8'hff);
            bus(1'b0, idx[i], 8'h0);
            check(rd, msk[i]);
        end
        bus(1'b1, IDX_CTRL, 8'h0a);
        bus(1'b1, IDX_MUX, 8'h1a);
        bus(1'b1, IDX_WIN, 8'h02);
        bus(1'b1, IDX_REF, 8'h40);
        idle(2);
        check(profileSel, 8'h1);
        check(hysteresisSel, 8'h1);
        check({positiveSel, negativeSel}, 8'h1a);
        check(partnerSel, 8'h2);
        check(refDividerCode, 8'h40);
        for (int i = 0; i < 4; i++)
            bus(1'b1, idx[i], 8'h0);
        bus(1'b1, IDX_REF, 8'h90);
    endtask : t_fields

    task automatic t_output();
        posPins <= 32'h20;
        bus(1'b1, IDX_MUX, 8'h40);
        bus(1'b1, IDX_CTRL, 8'h41);
        idle(2);
        check(padOut, 8'h1);
        check(anaEnable, 8'h1);
        idle(16);
        check({padOe, padOut, resultOut}, 8'h4);
        bus(1'b1, IDX_MUX, 8'hc0);
        idle(4);
        check({padOut, resultOut}, 8'h3);
        bus(1'b1, IDX_MUX, 8'h03);
        pin(8'h88);
        check(resultOut, 8'h0);
        pin(8'hc0);
        bus(1'b0, IDX_STAT, 8'h0);
        check(rd & 8'h10, 8'h10);
        bus(1'b1, IDX_CTRL, 8'h01);
        idle(4);
        check(padOe, 8'h0);
    endtask : t_output

    task automatic flag_is(input logic [7:0] modeEn, input logic [7:0] lvl,
        input logic [1:0] exp);
        bus(1'b1, IDX_IRQ, modeEn);
        bus(1'b1, IDX_STAT, 8'h01);
        pin(lvl);
        bus(1'b0, IDX_STAT, 8'h0);
        check({rd[0], irq}, {6'h0, exp});
    endtask : flag_is

    task automatic t_flag();
        flag_is(8'h31, 8'h20, 2'b00);
        flag_is(8'h31, 8'hc0, 2'b11);
        flag_is(8'h21, 8'h20, 2'b11);
        flag_is(8'h01, 8'hc0, 2'b11);
        flag_is(8'h00, 8'h20, 2'b10);
        bus(1'b1, IDX_IRQ, 8'h01);
        idle(2);
        check(irq, 8'h1);
        bus(1'b1, IDX_STAT, 8'h00);
        idle(2);
        check(irq, 8'h1);
        bus(1'b1, IDX_STAT, 8'h01);
        idle(2);
        check(irq, 8'h0);
    endtask : t_flag

    task automatic t_window();
        bus(1'b1, IDX_MUX, 8'h00);
        bus(1'b1, IDX_WIN, 8'h01);
        flag_is(8'h11, 8'h60, 2'b11);
        check(rd, 8'h51);
        flag_is(8'h11, 8'h20, 2'b00);
        check(rd, 8'h80);
        bus(1'b1, IDX_IRQ, 8'h31);
        idle(8);
        bus(1'b0, IDX_STAT, 8'h0);
        check(rd & 8'hd0, 8'h90);
        bus(1'b1, IDX_WIN, 8'h00);
    endtask : t_window

    task automatic t_sleep();
        bus(1'b1, IDX_IRQ, 8'h01);
        bus(1'b1, IDX_CTRL, 8'h41);
        bus(1'b1, IDX_STAT, 8'h01);
        standby <= 1'b1;
        pin(8'hc0);
        check(anaEnable, 8'h0);
        check(irq, 8'h0);
        standby <= 1'b0;
        idle(30);
        bus(1'b1, IDX_CTRL, 8'hc1);
        bus(1'b1, IDX_STAT, 8'h01);
        standby <= 1'b1;
        pin(8'h20);
        check({anaEnable, padOe, padOut, irq}, 8'hc);
        standby <= 1'b0;
        powerDown <= 1'b1;
        idle(4);
        check({anaEnable, padOe}, 8'h0);
        powerDown <= 1'b0;
    endtask : t_sleep

    initial
    begin
        idle(8);
        rstN <= 1'b1;
        t_reset();
        t_fields();
        t_output();
        t_flag();
        t_window();
        t_sleep();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
